// ### hdl/uart_flow_control_port.v
// Flow-controlled asynchronous serial port with its buffers.
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_defines.vh"

// ----------------------------------------------------------------
// Synchronous FIFO with registered full and empty flags
// ----------------------------------------------------------------
module sync_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire flush,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output wire [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready,
  output reg [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = mem[rd_ptr];

  // Storage has no reset; the flags guard every read of it.
  always @(posedge clk)
  begin
    if (ce && push && !flush)
      mem[wr_ptr] <= in_data;
  end

  // Pointers and flags; a flush drops every word held.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        level <= {(AW+1){1'b0}};
        in_ready <= 1'b1;
        out_valid <= 1'b0;
      end
      else
      begin
        if (push)
          wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
        if (pop)
          rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        level <= next_level;
        in_ready <= (next_level != DEPTH[AW:0]);
        out_valid <= (next_level != {(AW+1){1'b0}});
      end
    end
  end
endmodule

// Functional notes
// - Ten bit rates, 57600 default.
// - Formats none/8, even/7, odd/7; none default.
// - One start bit, one stop bit.
// - Seven data plus parity, or eight data.
// - Five flow modes, DTR/DSR default.
// - DTR/DSR mode sends only while DSR true.
// - DTR false near 100 buffered characters.
// - RTS/CTS mode sends only while CTS true.
// - RTS false near 100 buffered characters.
// - Modem mode asserts DTR when port active.
// - XOFF 13H pauses, XON 11H resumes sending.
// - Break aborts and discards pending output.
module uart_flow_control_port (
  input wire I_CLK_SYS,
  input wire I_RSTN,
  input wire I_CE,
  input wire [3:0] I_BAUD_SEL,
  input wire [1:0] I_FORMAT_SEL,
  input wire [2:0] I_FLOW_SEL,
  input wire I_SERIAL_ACTIVE,
  input wire [7:0] I_TX_DATA,
  input wire I_TX_VALID,
  output wire O_TX_READY,
  output reg [7:0] O_RX_DATA,
  output reg O_RX_VALID,
  input wire I_RX_READY,
  output reg O_RX_PARITY_ERR,
  output reg O_RX_FRAME_ERR,
  output reg O_BREAK,
  input wire I_RXD,
  input wire I_DSR,
  input wire I_CTS,
  output reg O_TXD,
  output reg O_DTR,
  output reg O_RTS
);
  localparam TX_IDLE = 4'h1;
  localparam TX_START = 4'h2;
  localparam TX_DATA = 4'h4;
  localparam TX_STOP = 4'h8;
  localparam RX_IDLE = 5'h01;
  localparam RX_START = 5'h02;
  localparam RX_DATA = 5'h04;
  localparam RX_STOP = 5'h08;
  localparam RX_WAIT_MARK = 5'h10;

  // --------------------------------------------------------------
  // Configuration decode
  // --------------------------------------------------------------
  // Unused codes fall back to the default settings.
  // default bit rate
  wire [3:0] baud_sel = (I_BAUD_SEL > 4'h9) ? `BAUD_SEL_DEFAULT : I_BAUD_SEL;
  wire parity_en = (I_FORMAT_SEL == `FMT_EVEN_7) || (I_FORMAT_SEL == `FMT_ODD_7);
  wire parity_odd = (I_FORMAT_SEL == `FMT_ODD_7);
  wire [2:0] flow = (I_FLOW_SEL > `FLOW_XON_XOFF) ? `FLOW_DTR_DSR : I_FLOW_SEL;

  // Cycles per oversample tick, rounded to the nearest cycle.
  function [13:0] tick_div;
    input [3:0] sel;
    reg [31:0] rate;
    reg [31:0] full;
    begin
      case (sel)
        4'h0: rate = `BAUD_300;
        4'h1: rate = `BAUD_600;
        4'h2: rate = `BAUD_1200;
        4'h3: rate = `BAUD_2400;
        4'h4: rate = `BAUD_4800;
        4'h5: rate = `BAUD_9600;
        4'h6: rate = `BAUD_19200;
        4'h7: rate = `BAUD_38400;
        4'h9: rate = `BAUD_115200;
        default: rate = `BAUD_57600;
      endcase
      full = (`CLK_HZ + rate * (`OVERSAMPLE / 2)) / (rate * `OVERSAMPLE);
      tick_div = full[13:0];
    end
  endfunction

  // --------------------------------------------------------------
  // Pin synchronisers and oversample tick
  // --------------------------------------------------------------
  reg [1:0] rxd_sync;
  reg [1:0] dsr_sync;
  reg [1:0] cts_sync;
  reg [13:0] div_cnt;
  reg tick;
  wire [13:0] div_last = tick_div(baud_sel) - 14'h0001;
  wire rxd = rxd_sync[1];

  always @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rxd_sync <= 2'h3;
      dsr_sync <= 2'h0;
      cts_sync <= 2'h0;
      div_cnt <= 14'h0000;
      tick <= 1'b0;
    end
    else if (I_CE)
    begin
      rxd_sync <= {rxd_sync[0], I_RXD};
      dsr_sync <= {dsr_sync[0], I_DSR};
      cts_sync <= {cts_sync[0], I_CTS};
      tick <= (div_cnt >= div_last);
      div_cnt <= (div_cnt >= div_last) ? 14'h0000 : div_cnt + 14'h0001;
    end
  end

  // --------------------------------------------------------------
  // Buffers
  // --------------------------------------------------------------
  wire [7:0] txq_data;
  wire txq_valid;
  wire txq_pop;
  wire [7:0] rxq_data;
  wire rxq_valid;
  wire [`RX_FIFO_AW:0] rxq_level;
  reg break_hit;
  reg rx_push;
  reg [7:0] rx_char;
  wire rxq_pop = rxq_valid & (~O_RX_VALID | I_RX_READY);

  sync_fifo #(.WIDTH(8), .DEPTH(`TX_FIFO_DEPTH), .AW(`TX_FIFO_AW)) tx_queue (
    .clk(I_CLK_SYS), .rstn(I_RSTN), .ce(I_CE), .flush(break_hit),
    .in_data(I_TX_DATA), .in_valid(I_TX_VALID), .in_ready(O_TX_READY),
    .out_data(txq_data), .out_valid(txq_valid), .out_ready(txq_pop), .level()
  );

  sync_fifo #(.WIDTH(8), .DEPTH(`RX_FIFO_DEPTH), .AW(`RX_FIFO_AW)) rx_queue (
    .clk(I_CLK_SYS), .rstn(I_RSTN), .ce(I_CE), .flush(1'b0),
    .in_data(rx_char), .in_valid(rx_push), .in_ready(),
    .out_data(rxq_data), .out_valid(rxq_valid), .out_ready(rxq_pop), .level(rxq_level)
  );

  // --------------------------------------------------------------
  // Transmit flow gating
  // --------------------------------------------------------------
  reg xoff;
  reg flow_ok;
  always @*
  begin
    case (flow)
      `FLOW_NONE: flow_ok = 1'b1;
      `FLOW_DTR_DSR: flow_ok = dsr_sync[1];
      `FLOW_MODEM: flow_ok = dsr_sync[1] & cts_sync[1];
      `FLOW_RTS_CTS: flow_ok = cts_sync[1];
      `FLOW_XON_XOFF: flow_ok = ~xoff;
      default: flow_ok = 1'b1;
    endcase
  end

  // --------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------
  // A character already started finishes unless a break aborts it, so the far end sees
  // at most one more frame after it withdraws permission.
  reg [3:0] tx_state;
  reg [3:0] tx_tick;
  reg [3:0] tx_bits;
  reg [7:0] tx_shift;
  // Frames begin on a tick, so the start bit lasts as long as every other bit.
  // full start bit
  assign txq_pop = (tx_state == TX_IDLE) & txq_valid & flow_ok & ~break_hit & tick;
  wire tx_par = (^txq_data[6:0]) ^ parity_odd;

  always @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      tx_state <= TX_IDLE;
      tx_tick <= 4'h0;
      tx_bits <= 4'h0;
      tx_shift <= 8'h00;
      O_TXD <= 1'b1;
    end
    else if (I_CE)
    begin
      if (break_hit)
      begin
        tx_state <= TX_IDLE;
        O_TXD <= 1'b1;
      end
      else
      begin
        case (tx_state)
          TX_IDLE:
          begin
            O_TXD <= 1'b1;
            if (txq_pop)
            begin
              O_TXD <= 1'b0;
              tx_shift <= parity_en ? {tx_par, txq_data[6:0]} : txq_data;
              tx_state <= TX_START;
              tx_tick <= 4'h0;
            end
          end
          TX_START:
          begin
            O_TXD <= 1'b0;
            if (tick)
            begin
              tx_tick <= tx_tick + 4'h1;
              if (tx_tick == `LAST_TICK)
              begin
                tx_state <= TX_DATA;
                tx_bits <= 4'h0;
                O_TXD <= tx_shift[0];
              end
            end
          end
          TX_DATA:
          begin
            O_TXD <= tx_shift[0];
            if (tick)
            begin
              tx_tick <= tx_tick + 4'h1;
              if (tx_tick == `LAST_TICK)
              begin
                tx_shift <= {1'b1, tx_shift[7:1]};
                tx_bits <= tx_bits + 4'h1;
                if (tx_bits == `FRAME_BITS - 4'h1)
                  tx_state <= TX_STOP;
              end
            end
          end
          TX_STOP:
          begin
            O_TXD <= 1'b1;
            if (tick)
            begin
              tx_tick <= tx_tick + 4'h1;
              if (tx_tick == `LAST_TICK)
                tx_state <= TX_IDLE;
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------
  reg [4:0] rx_state;
  reg [3:0] rx_tick;
  reg [3:0] rx_bits;
  reg [7:0] rx_shift;
  wire [7:0] rx_word = parity_en ? {1'b0, rx_shift[6:0]} : rx_shift;
  wire is_flow_char = (flow == `FLOW_XON_XOFF) &&
                      ((rx_word == `CHAR_XOFF) || (rx_word == `CHAR_XON));

  always @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rx_state <= RX_IDLE;
      rx_tick <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
      rx_char <= 8'h00;
      rx_push <= 1'b0;
      xoff <= 1'b0;
      break_hit <= 1'b0;
      O_BREAK <= 1'b0;
      O_RX_PARITY_ERR <= 1'b0;
      O_RX_FRAME_ERR <= 1'b0;
    end
    else if (I_CE)
    begin
      rx_push <= 1'b0;
      break_hit <= 1'b0;
      O_BREAK <= 1'b0;
      O_RX_PARITY_ERR <= 1'b0;
      O_RX_FRAME_ERR <= 1'b0;
      if (flow != `FLOW_XON_XOFF)
        xoff <= 1'b0;
      case (rx_state)
        RX_IDLE:
        begin
          rx_tick <= 4'h0;
          if (!rxd)
            rx_state <= RX_START;
        end
        RX_START:
        begin
          if (tick)
          begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == `MID_TICK)
            begin
              rx_tick <= 4'h0;
              rx_bits <= 4'h0;
              rx_state <= rxd ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA:
        begin
          if (tick)
          begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == `LAST_TICK)
            begin
              rx_shift <= {rxd, rx_shift[7:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == `FRAME_BITS - 4'h1)
                rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (tick)
          begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == `LAST_TICK)
            begin
              if (rxd)
              begin
                rx_state <= RX_IDLE;
                if (is_flow_char)
                  xoff <= (rx_word == `CHAR_XOFF);
                else
                begin
                  rx_char <= rx_word;
                  rx_push <= 1'b1;
                  O_RX_PARITY_ERR <= parity_en & ((^rx_shift) ^ parity_odd);
                end
              end
              else if (rx_shift == 8'h00)
              begin
                break_hit <= 1'b1;
                O_BREAK <= 1'b1;
                xoff <= 1'b0;
                rx_state <= RX_WAIT_MARK;
              end
              else
              begin
                O_RX_FRAME_ERR <= 1'b1;
                rx_state <= RX_WAIT_MARK;
              end
            end
          end
        end
        RX_WAIT_MARK:
        begin
          // A held-low line must return to mark before the next frame.
          if (rxd)
            rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Receive output stage and handshake lines
  // --------------------------------------------------------------
  // Throttling at the high-water mark leaves the far end room for the
  // few characters it may still send before it reacts.
  wire room = (rxq_level < `RX_HIGH_WATER);

  always @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_RX_DATA <= 8'h00;
      O_RX_VALID <= 1'b0;
      O_DTR <= 1'b0;
      O_RTS <= 1'b0;
    end
    else if (I_CE)
    begin
      if (rxq_pop)
        O_RX_DATA <= rxq_data;
      if (rxq_pop)
        O_RX_VALID <= 1'b1;
      else if (I_RX_READY)
        O_RX_VALID <= 1'b0;
      case (flow)
        `FLOW_DTR_DSR: O_DTR <= room;
        `FLOW_MODEM: O_DTR <= I_SERIAL_ACTIVE;
        default: O_DTR <= 1'b1;
      endcase
      if (flow == `FLOW_RTS_CTS || flow == `FLOW_MODEM)
        O_RTS <= room;
      else
        O_RTS <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### hdl/uart_flow_defines.vh
// Constants for the flow-controlled asynchronous serial port.
`ifndef UART_FLOW_DEFINES_VH
`define UART_FLOW_DEFINES_VH

// ----------------------------------------------------------------
// Clock and bit timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define OVERSAMPLE 16
`define MID_TICK 4'h7
`define LAST_TICK 4'hF
`define FRAME_BITS 4'h8

// ----------------------------------------------------------------
// Bit rate select codes and rates
// ----------------------------------------------------------------
`define BAUD_300 300
`define BAUD_600 600
`define BAUD_1200 1200
`define BAUD_2400 2400
`define BAUD_4800 4800
`define BAUD_9600 9600
`define BAUD_19200 19200
`define BAUD_38400 38400
`define BAUD_57600 57600
`define BAUD_115200 115200
`define BAUD_SEL_DEFAULT 4'h8

// ----------------------------------------------------------------
// Character format and flow mode codes
// ----------------------------------------------------------------
`define FMT_NONE_8 2'h0
`define FMT_EVEN_7 2'h1
`define FMT_ODD_7 2'h2
`define FLOW_NONE 3'h0
`define FLOW_DTR_DSR 3'h1
`define FLOW_MODEM 3'h2
`define FLOW_RTS_CTS 3'h3
`define FLOW_XON_XOFF 3'h4

// ----------------------------------------------------------------
// Flow characters and buffer sizes
// ----------------------------------------------------------------
`define CHAR_XOFF 8'h13
`define CHAR_XON 8'h11
`define RX_HIGH_WATER 100
`define TX_FIFO_DEPTH 8
`define TX_FIFO_AW 3
`define RX_FIFO_DEPTH 128
`define RX_FIFO_AW 7

`endif

// ### verification/uart_flow_port_chk_sva.sv
// Assertions on the pins of the flow-controlled serial port.
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_defines.vh"
module uart_flow_port_chk (
  input wire I_CLK_SYS,
  input wire I_RSTN,
  input wire I_CE,
  input wire [3:0] I_BAUD_SEL,
  input wire [2:0] I_FLOW_SEL,
  input wire I_SERIAL_ACTIVE,
  input wire I_TX_VALID,
  input wire O_TX_READY,
  input wire [7:0] O_RX_DATA,
  input wire O_RX_VALID,
  input wire I_RX_READY,
  input wire O_BREAK,
  input wire I_RXD,
  input wire I_DSR,
  input wire I_CTS,
  input wire O_TXD,
  input wire O_DTR,
  input wire O_RTS
);
  logic [11:0] hi_run;
  logic [9:0] lo_run;
  logic [4:0] dsr_h;
  logic [4:0] cts_h;
  logic [1:0] up;
  wire settled = (up == 2'h3) && I_CE;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Run lengths saturate so that a long idle never wraps back into range.
  always @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      hi_run <= 12'h000;
      lo_run <= 10'h000;
      dsr_h <= 5'h00;
      cts_h <= 5'h00;
      up <= 2'h0;
    end
    else
    begin
      hi_run <= !O_TXD ? 12'h000 : hi_run + {11'h000, hi_run != 12'hFFF};
      lo_run <= O_TXD ? 10'h000 : lo_run + {9'h000, lo_run != 10'h3FF};
      dsr_h <= {dsr_h[3:0], I_DSR};
      cts_h <= {cts_h[3:0], I_CTS};
      // A pause of the enable restarts settling, since outputs lag the first enabled edge.
      up <= I_CE ? up + {1'b0, up != 2'h3} : 2'h0;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // whole bit times
  property p_bit_len;
    $rose(O_TXD) && I_BAUD_SEL == 4'h9 && !$past(O_BREAK) && !$past(O_BREAK, 2) |-> lo_run >= 10'd352;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("Low run on the line is shorter than one bit.");
  property p_dsr_gate;
    $fell(O_TXD) && hi_run > 12'd3520 && I_FLOW_SEL == `FLOW_DTR_DSR |-> dsr_h != 5'h00;
  endproperty
  a_dsr_gate: assert property (p_dsr_gate) else $error("Frame started while the peer was not ready.");
  property p_cts_gate;
    $fell(O_TXD) && hi_run > 12'd3520 && I_FLOW_SEL == `FLOW_RTS_CTS |-> cts_h != 5'h00;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("Frame started while the peer was not clear.");
  property p_modem_dtr;
    settled && I_FLOW_SEL == `FLOW_MODEM && $stable(I_FLOW_SEL) && $stable(I_SERIAL_ACTIVE) |-> O_DTR == I_SERIAL_ACTIVE;
  endproperty
  a_modem_dtr: assert property (p_modem_dtr) else $error("Terminal ready does not follow port selection.");
  property p_open_hs;
    settled && $stable(I_FLOW_SEL) && I_FLOW_SEL inside {`FLOW_NONE, `FLOW_XON_XOFF, `FLOW_DTR_DSR}
      |-> O_RTS && (O_DTR || I_FLOW_SEL == `FLOW_DTR_DSR);
  endproperty
  a_open_hs: assert property (p_open_hs) else $error("Handshake line low in a mode that keeps it high.");
  property p_tx_ready;
    $fell(O_TX_READY) |-> $past(I_TX_VALID) && $past(I_CE);
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("Transmit buffer became full without a write.");
  property p_break;
    O_BREAK |-> !$past(I_RXD, 4) && !$past(I_RXD, 5) ##1 !O_BREAK ##1 O_TXD [*8];
  endproperty
  a_break: assert property (p_break) else $error("Break pulse or transmit abort is wrong.");
  property p_rx_hold;
    O_RX_VALID && !I_RX_READY |=> O_RX_VALID && $stable(O_RX_DATA);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("Received character dropped before it was taken.");
  c_break: cover property (O_BREAK);
  c_rx_take: cover property (O_RX_VALID && I_RX_READY);
  c_gate_open: cover property ($fell(O_TXD) && hi_run > 12'd3520 && dsr_h != 5'h00);
endmodule
bind uart_flow_control_port uart_flow_port_chk u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_BAUD_SEL(I_BAUD_SEL), .I_FLOW_SEL(I_FLOW_SEL),
  .I_SERIAL_ACTIVE(I_SERIAL_ACTIVE), .I_TX_VALID(I_TX_VALID), .O_TX_READY(O_TX_READY), .O_RX_DATA(O_RX_DATA),
  .O_RX_VALID(O_RX_VALID), .I_RX_READY(I_RX_READY), .O_BREAK(O_BREAK), .I_RXD(I_RXD), .I_DSR(I_DSR),
  .I_CTS(I_CTS), .O_TXD(O_TXD), .O_DTR(O_DTR), .O_RTS(O_RTS)
);
`default_nettype wire

// ### verification/serial_host_model.sv
// Host serial port model that frames characters to the port and reads its output.
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  input wire logic i_clk,
  input wire logic i_txd,
  output var logic o_rxd,
  output var logic o_dsr,
  output var logic o_cts
);
  int bit_cyc = 352;
  // ----------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------
  // The line idles at mark and both readiness lines start true.
  initial
  begin
    o_rxd = 1'b1;
    o_dsr = 1'b1;
    o_cts = 1'b1;
  end
  task automatic set_lines(input logic dsr_v, input logic cts_v);
    @(negedge i_clk);
    o_dsr = dsr_v;
    o_cts = cts_v;
  endtask
  task automatic send(input logic [7:0] d, input logic stop_v);
    logic [9:0] fr;
    fr = {stop_v, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_rxd = fr[i];
      repeat (bit_cyc) @(negedge i_clk);
    end
    o_rxd = 1'b1;
    repeat (bit_cyc) @(negedge i_clk);
  endtask
  // Samples at bit centres; the result is {stop, eight slots}, slot 0 first on the line.
  task automatic recv(output logic [8:0] f, output logic ok);
    int n;
    n = 0;
    f = 9'h000;
    while (i_txd !== 1'b0 && n < 20000)
    begin
      @(negedge i_clk);
      n++;
    end
    repeat (bit_cyc / 2) @(negedge i_clk);
    ok = (n < 20000) && (i_txd === 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bit_cyc) @(negedge i_clk);
      f[i] = i_txd;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/test_uart_flow_control_port.sv
// Self-checking bench for the flow-controlled serial port.
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_defines.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module test_uart_flow_control_port;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic act = 1'b1;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic [3:0] baud = 4'h9;
  logic [1:0] fmt = `FMT_NONE_8;
  logic [2:0] flow = `FLOW_DTR_DSR;
  logic [7:0] tx_data = 8'h00;
  wire tx_ready, rx_valid, perr, ferr, brk, rxd, dsr, cts, txd, dtr, rts;
  wire [7:0] rx_data;
  int fail_count = 0;
  int checks_done = 0;
  int perr_seen = 0;
  int brk_seen = 0;
  int ferr_seen = 0;
  int cyc = 0;
  uart_flow_control_port DUT (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_CE(ce), .I_BAUD_SEL(baud), .I_FORMAT_SEL(fmt),
    .I_FLOW_SEL(flow), .I_SERIAL_ACTIVE(act), .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready),
    .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .O_RX_PARITY_ERR(perr),
    .O_RX_FRAME_ERR(ferr), .O_BREAK(brk), .I_RXD(rxd), .I_DSR(dsr), .I_CTS(cts), .O_TXD(txd), .O_DTR(dtr),
    .O_RTS(rts));
  serial_host_model host (.i_clk(clk), .i_txd(txd), .o_rxd(rxd), .o_dsr(dsr), .o_cts(cts));
  // ----------------------------------------------------------------
  // Clock, pulse counters and hang limit
  // ----------------------------------------------------------------
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Pulses last one cycle, so they are counted as they pass; the limit is well above the planned run.
  always @(posedge clk)
  begin
    cyc++;
    if (perr === 1'b1)
      perr_seen++;
    if (brk === 1'b1)
      brk_seen++;
    if (ferr === 1'b1)
      ferr_seen++;
    if (cyc == 100000)
    begin
      fail_count++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Shared drivers
  // ----------------------------------------------------------------
  task automatic cfg(input logic [3:0] b, input logic [1:0] f, input logic [2:0] fl);
    @(negedge clk);
    baud = b;
    fmt = f;
    flow = fl;
  endtask
  task automatic put(input logic [7:0] d);
    @(negedge clk);
    tx_data = d;
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1)
      @(posedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic expect_frame(input string nm, input logic [8:0] ex);
    logic [8:0] f;
    logic ok;
    host.recv(f, ok);
    `CHK("frame start", 1'b1, ok)
    `CHK(nm, ex, f)
  endtask
  task automatic rx_check(input logic [7:0] s, input logic [7:0] ex, input int pe);
    int p0;
    p0 = perr_seen;
    host.send(s, 1'b1);
    for (int n = 0; n < 50 && rx_valid !== 1'b1; n++)
      @(negedge clk);
    `CHK("rx data", ex, rx_data)
    `CHK("parity flags", pe, perr_seen - p0)
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    repeat (6) @(negedge clk);
    `CHK("txd in reset", 1'b1, txd)
    `CHK("dtr in reset", 1'b0, dtr)
    `CHK("ready in reset", 1'b1, tx_ready)
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("dtr default", 1'b1, dtr)
    `CHK("rts default", 1'b1, rts)
  endtask
  // Bit 7 of the word is set on purpose: the 7-bit formats must replace it by parity.
  task automatic t_formats;
    logic [6:0] d;
    d = 7'h35;
    for (int k = 0; k < 3; k++)
    begin
      cfg(4'h9, k[1:0], `FLOW_NONE);
      put(8'hB5);
      expect_frame("format frame", k == 0 ? 9'h1B5 : {1'b1, (^d) ^ (k == 2), d});
    end
    cfg(4'hF, `FMT_NONE_8, `FLOW_NONE);
    host.bit_cyc = 688;
    put(8'h5A);
    expect_frame("default rate frame", 9'h15A);
    host.bit_cyc = 352;
  endtask
  task automatic t_gate;
    for (int k = 0; k < 2; k++)
    begin
      cfg(4'h9, `FMT_NONE_8, k == 0 ? `FLOW_DTR_DSR : `FLOW_RTS_CTS);
      host.set_lines(k != 0, k == 0);
      put(8'h3C);
      repeat (3600) @(negedge clk);
      `CHK("txd held", 1'b1, txd)
      host.set_lines(1'b1, 1'b1);
      expect_frame("gated frame", 9'h13C);
    end
    cfg(4'h9, `FMT_NONE_8, `FLOW_MODEM);
    act = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("modem dtr off", 1'b0, dtr)
    // With the enable low the new selection must not reach the pin.
    ce = 1'b0;
    act = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("dtr frozen", 1'b0, dtr)
    ce = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("modem dtr on", 1'b1, dtr)
  endtask
  task automatic t_xon;
    cfg(4'h9, `FMT_NONE_8, `FLOW_XON_XOFF);
    host.send(`CHAR_XOFF, 1'b1);
    put(8'h42);
    repeat (3600) @(negedge clk);
    `CHK("txd paused", 1'b1, txd)
    `CHK("flow char consumed", 1'b0, rx_valid)
    fork
      host.send(`CHAR_XON, 1'b1);
      expect_frame("resumed frame", 9'h142);
    join
  endtask
  task automatic t_rx;
    int fe;
    cfg(4'h9, `FMT_NONE_8, `FLOW_NONE);
    rx_check(8'hC3, 8'hC3, 0);
    cfg(4'h9, `FMT_EVEN_7, `FLOW_NONE);
    rx_check(8'h4B, 8'h4B, 0);
    rx_check(8'hCB, 8'h4B, 1);
    cfg(4'h9, `FMT_ODD_7, `FLOW_NONE);
    rx_check(8'hCB, 8'h4B, 0);
    // A low stop bit under non-zero data is a framing error and the character is dropped.
    fe = ferr_seen;
    host.send(8'h5A, 1'b0);
    `CHK("frame errors", 1, ferr_seen - fe)
    `CHK("bad frame dropped", 1'b0, rx_valid)
  endtask
  // Eight words fill the buffer behind a not-ready peer; the break must throw all of them away.
  task automatic t_break;
    int lows;
    lows = 0;
    cfg(4'h9, `FMT_NONE_8, `FLOW_DTR_DSR);
    host.set_lines(1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
      put(8'h11 + i[7:0]);
    `CHK("buffer full", 1'b0, tx_ready)
    host.send(8'h00, 1'b0);
    `CHK("break pulses", 1, brk_seen)
    host.set_lines(1'b1, 1'b1);
    repeat (1500)
    begin
      @(negedge clk);
      lows += (txd !== 1'b1);
    end
    `CHK("low samples after break", 0, lows)
    `CHK("buffer empty", 1'b1, tx_ready)
  endtask
  initial
  begin
    t_reset;
    t_formats;
    t_gate;
    t_xon;
    t_rx;
    t_break;
    finish_test;
  end
endmodule
`default_nettype wire
